//--- dv/flr_lock_regs_tb.sv
// self-checking bench for the lock password and otp readback registers
// assumes the nonvolatile model content is addr xor C3
`timescale 1ns/1ps
`include "flr_params.svh"

module flr_lock_regs_tb;
  logic       clk, rst_n, reg_wr, reg_rd, reg_rvalid, reg_hit, guard_req, guard_ok;
  logic       nvm_rd_en, nvm_rd_valid, boot_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nvm_rd_addr, nvm_rd_data;
  logic [1:0] guard_group;
  logic [2:0] guard_bit;
  logic [7:0] msk [3];
  logic [7:0] st [3];
  logic [7:0] ref_lock [3];
  int         bad_count, samples_checked;

  always #2 clk = ~clk;

  flr_lock_regs i_flr_lock_regs (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit), .lock_exclusion_first(msk[0]), .lock_exclusion_second(msk[1]),
    .lock_exclusion_third(msk[2]), .lock_state_first(st[0]), .lock_state_second(st[1]),
    .lock_state_third(st[2]), .guard_req(guard_req), .guard_group(guard_group), .guard_bit(guard_bit),
    .guard_ok(guard_ok), .nvm_rd_en(nvm_rd_en), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_valid(nvm_rd_valid),
    .nvm_rd_data(nvm_rd_data), .boot_done(boot_done));

  flr_nvm_model i_flr_nvm_model (.clk(clk), .rst_n(rst_n), .nvm_rd_en(nvm_rd_en),
    .nvm_rd_addr(nvm_rd_addr), .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  // write strobe held for one sampled edge, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read answer lands one cycle after the strobe and lasts one cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp1(reg_rvalid, 1'b1);
    cmp1(reg_hit, a >= `FLR_ADDR_PW_FIRST && a <= `FLR_ADDR_OTP_DATA);
    cmp8(reg_rdata, exp);
    @(posedge clk);
    #1;
    cmp1(reg_rvalid, 1'b0);
  endtask

  task automatic chk_state;
    for (int i = 0; i < 3; i++) cmp8(st[i], ref_lock[i]);
  endtask

  // watchdog: a hang anywhere ends the run as a failure
  initial begin
    #200000;
    bad_count++;
    give_verdict;
  end

  initial begin
    int         n, g, k;
    logic [7:0] a, m, c;
    clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    guard_req = 1'b0; guard_group = 2'h0; guard_bit = 3'h0; bad_count = 0; samples_checked = 0;
    for (int i = 0; i < 3; i++) begin
      msk[i]      = 8'hFF;
      ref_lock[i] = `FLR_LOCK_RST;
    end
    void'($urandom(63483));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_state;
    for (int i = 0; i < 3; i++) rd(8'(8'h8A + i), 8'hFF);
    rd(`FLR_ADDR_OTP_DATA, 8'h00);
    rd(8'h80, 8'h00);
    for (n = 0; n < 3000 && boot_done !== 1'b1; n++) @(posedge clk);
    cmp1(boot_done, 1'b1);
    // readback at both ends of the file and at random bytes
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? `FLR_OTP_LAST : 8'($urandom);
      wr(`FLR_ADDR_OTP_SEL, a);
      rd(`FLR_ADDR_OTP_SEL, a);
      rd(`FLR_ADDR_OTP_DATA, a ^ 8'hC3);
    end
    wr(`FLR_ADDR_OTP_DATA, 8'h3C);
    rd(`FLR_ADDR_OTP_SEL, a);
    rd(`FLR_ADDR_OTP_DATA, a ^ 8'hC3);
    // select then read with no idle cycle between, as the host engine may issue them
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= `FLR_ADDR_OTP_SEL;
    reg_wdata <= ~a;
    @(posedge clk);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= `FLR_ADDR_OTP_DATA;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp8(reg_rdata, ~a ^ 8'hC3);
    // random masks and codes on random groups, guard probed after each
    for (int i = 0; i < 80; i++) begin
      g = $urandom_range(0, 2);
      m = 8'($urandom);
      k = $urandom_range(0, 2);
      c = (k == 0) ? `FLR_CODE_UNLOCK : (k == 1) ? `FLR_CODE_LOCK : 8'($urandom);
      @(posedge clk);
      msk[g] <= m;
      if (c == `FLR_CODE_UNLOCK) ref_lock[g] &= m;
      else if (c == `FLR_CODE_LOCK) ref_lock[g] |= ~m;
      wr(8'(8'h8A + g), c);
      chk_state;
      rd(8'(8'h8A + g), ref_lock[g]);
      @(posedge clk);
      guard_req   <= 1'($urandom);
      guard_group <= 2'($urandom);
      guard_bit   <= 3'($urandom);
      #1;
      cmp1(guard_ok, guard_req && (guard_group == 2'h3 || !ref_lock[guard_group][guard_bit]));
    end
    wr(8'h80, `FLR_CODE_UNLOCK);
    chk_state;
    give_verdict;
  end
endmodule

//--- dv/flr_nvm_model.sv
// nonvolatile block model answering the boot reads of the otp loader
// assumes one outstanding request; answers 1 to 3 cycles late, at random
`timescale 1ns/1ps

module flr_nvm_model (
  input  wire logic       clk,           // register clock
  input  wire logic       rst_n,         // async reset, active low
  input  wire logic       nvm_rd_en,     // read request
  input  wire logic [7:0] nvm_rd_addr,   // byte address
  output logic            nvm_rd_valid,  // answer present, one cycle
  output logic [7:0]      nvm_rd_data    // answer data
);
  logic       busy;
  logic [1:0] wait_cnt;
  logic [7:0] addr_q;

  // content is addr xor C3 so the bench can predict it; idle data toggles so stale bytes never match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy         <= 1'b0;
      wait_cnt     <= 2'h0;
      addr_q       <= 8'h00;
      nvm_rd_valid <= 1'b0;
      nvm_rd_data  <= 8'h00;
    end else begin
      nvm_rd_valid <= 1'b0;
      nvm_rd_data  <= ~nvm_rd_data;
      if (!busy && nvm_rd_en) begin
        busy     <= 1'b1;
        wait_cnt <= 2'($urandom_range(0, 2));
        addr_q   <= nvm_rd_addr;
      end else if (busy && wait_cnt == 2'h0) begin
        busy         <= 1'b0;
        nvm_rd_valid <= 1'b1;
        nvm_rd_data  <= addr_q ^ 8'hC3;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

//--- inc/flr_params.svh
// constants for the function lock and otp readback register bank
// assumes an 8-bit register address and 8-bit register data path
`ifndef FLR_PARAMS_SVH
`define FLR_PARAMS_SVH

// register offsets
`define FLR_ADDR_PW_FIRST  8'h8A
`define FLR_ADDR_PW_SECOND 8'h8B
`define FLR_ADDR_PW_THIRD  8'h8C
`define FLR_ADDR_OTP_SEL   8'h8D
`define FLR_ADDR_OTP_DATA  8'h8E

// password codes
`define FLR_CODE_UNLOCK    8'h55
`define FLR_CODE_LOCK      8'hAA

// reset values
`define FLR_LOCK_RST       8'hFF
`define FLR_SEL_RST        8'h00
`define FLR_DATA_RST       8'h00

// otp register file geometry and lock group count
`define FLR_OTP_DEPTH      256
`define FLR_OTP_LAST       8'hFF
`define FLR_GROUPS         3

`endif

//--- inc/flr_pkg.sv
// types shared by the lock register bank and its otp register file
// assumes flr_params.svh is on the include path
`include "flr_params.svh"

package flr_pkg;

  // boot walk of the otp register file
  typedef enum logic [1:0] {
    FLR_BOOT_REQ,
    FLR_BOOT_WAIT,
    FLR_READY
  } flr_boot_t;

  // state of the otp loader
  typedef struct packed {
    flr_boot_t  st;
    logic [7:0] addr;
    logic       done;
  } flr_otp_st_t;

  // state of the lock register bank
  typedef struct packed {
    logic [2:0][7:0] lock;
    logic [7:0]      sel;
    logic [7:0]      rdata;
    logic            rvalid;
  } flr_regs_t;

endpackage

//--- src/flr_lock_regs.sv
// function lock password registers and otp readback registers
// assumes a register engine on clk that gives one-cycle read and write strobes
//
// Contract
// RL1: writing the unlock code to a password register unlocks every function its mask leaves unmasked.
// RL2: writing the lock code to a password register locks every function its mask leaves unmasked.
// RL3: writing any other value to a password register changes no lock state.
// RL4: each password register acts only through its own paired mask, first, second and third.
// RL5: reading a password register returns the current lock state, not the last written value.
// RL6: a read lock bit is 1 when its function is locked and 0 when it is unlocked.
// RL7: lock state bits sit in the same function order as the paired mask bits.
// RL8: the readback address register picks which otp file byte the readback data register shows.
// RL9: the otp register file is loaded from the nonvolatile block during boot.
// RL10: a write to a bitfield of a locked function is ignored.
// RL11: a mask bit of 1 keeps its function out of locking and unlocking, 0 lets it change.
// RL12: writes to the read-only readback data register change nothing.
`timescale 1ns/1ps
`include "flr_params.svh"

module flr_lock_regs (
  input  wire logic       clk,                    // register clock
  input  wire logic       rst_n,                  // async reset, active low
  input  wire logic       reg_wr,                 // register write strobe
  input  wire logic       reg_rd,                 // register read strobe
  input  wire logic [7:0] reg_addr,               // register address
  input  wire logic [7:0] reg_wdata,              // write data
  output logic [7:0]      reg_rdata,              // read data, registered
  output logic            reg_rvalid,             // read data valid pulse
  output logic            reg_hit,                // address belongs to this bank
  input  wire logic [7:0] lock_exclusion_first,   // first mask, 1 = excluded
  input  wire logic [7:0] lock_exclusion_second,  // second mask, 1 = excluded
  input  wire logic [7:0] lock_exclusion_third,   // third mask, 1 = excluded
  output logic [7:0]      lock_state_first,       // lock state, first group
  output logic [7:0]      lock_state_second,      // lock state, second group
  output logic [7:0]      lock_state_third,       // lock state, third group
  input  wire logic       guard_req,              // protected field write request
  input  wire logic [1:0] guard_group,            // group of the field
  input  wire logic [2:0] guard_bit,              // function bit of the field
  output logic            guard_ok,               // write may proceed
  output logic            nvm_rd_en,              // nonvolatile read request
  output logic [7:0]      nvm_rd_addr,            // nonvolatile byte address
  input  wire logic       nvm_rd_valid,           // nonvolatile data present
  input  wire logic [7:0] nvm_rd_data,            // nonvolatile data
  output logic            boot_done               // otp file loaded
);

  flr_pkg::flr_regs_t r_q, r_d;

  logic [2:0][7:0] mask;
  logic [2:0][7:0] lock_nx;
  logic [2:0]      pw_wr;
  logic [7:0]      otp_byte;

  assign mask[0] = lock_exclusion_first;
  assign mask[1] = lock_exclusion_second;
  assign mask[2] = lock_exclusion_third;

  // write strobes for each password register
  assign pw_wr[0] = reg_wr && (reg_addr == `FLR_ADDR_PW_FIRST);
  assign pw_wr[1] = reg_wr && (reg_addr == `FLR_ADDR_PW_SECOND);
  assign pw_wr[2] = reg_wr && (reg_addr == `FLR_ADDR_PW_THIRD);

  // one update per group; each group only sees its own mask
  for (genvar g = 0; g < `FLR_GROUPS; g++) begin : g_lock
    always_comb begin
      if (pw_wr[g] && reg_wdata == `FLR_CODE_UNLOCK) begin
        lock_nx[g] = r_q.lock[g] & mask[g];        // [RL1] [RL4] [RL11]
      end else if (pw_wr[g] && reg_wdata == `FLR_CODE_LOCK) begin
        lock_nx[g] = r_q.lock[g] | ~mask[g];       // [RL2] [RL4] [RL11]
      end else begin
        lock_nx[g] = r_q.lock[g];                  // [RL3]
      end
    end
  end

  // otp file with boot loader
  flr_otp_file u_otp (
    .clk          (clk),
    .rst_n        (rst_n),
    .nvm_rd_en    (nvm_rd_en),
    .nvm_rd_addr  (nvm_rd_addr),
    .nvm_rd_valid (nvm_rd_valid),
    .nvm_rd_data  (nvm_rd_data),
    .rd_sel       (r_q.sel),
    .rd_byte      (otp_byte),
    .boot_done    (boot_done)
  );

  // address decode for the engine, used to acknowledge or refuse
  always_comb begin
    case (reg_addr)
      `FLR_ADDR_PW_FIRST,
      `FLR_ADDR_PW_SECOND,
      `FLR_ADDR_PW_THIRD,
      `FLR_ADDR_OTP_SEL,
      `FLR_ADDR_OTP_DATA: reg_hit = 1'b1;
      default:            reg_hit = 1'b0;
    endcase
  end

  // next state of the bank
  always_comb begin
    r_d        = r_q;
    r_d.lock   = lock_nx;
    r_d.rvalid = reg_rd;
    // of the readback pair only the select register takes writes; the data register is read only [RL12]
    if (reg_wr && reg_addr == `FLR_ADDR_OTP_SEL) begin
      r_d.sel = reg_wdata;                         // [RL8]
    end
    // a read shows live lock state, bit order as in the paired mask [RL5] [RL6] [RL7]
    if (reg_rd) begin
      case (reg_addr)
        `FLR_ADDR_PW_FIRST:  r_d.rdata = r_q.lock[0];
        `FLR_ADDR_PW_SECOND: r_d.rdata = r_q.lock[1];
        `FLR_ADDR_PW_THIRD:  r_d.rdata = r_q.lock[2];
        `FLR_ADDR_OTP_SEL:   r_d.rdata = r_q.sel;
        `FLR_ADDR_OTP_DATA:  r_d.rdata = otp_byte; // [RL8]
        default:             r_d.rdata = 8'h00;
      endcase
    end
  end

  // reset leaves every function locked, the safe state until software unlocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{lock:   {`FLR_LOCK_RST, `FLR_LOCK_RST, `FLR_LOCK_RST},
               sel:    `FLR_SEL_RST,
               rdata:  `FLR_DATA_RST,
               rvalid: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // a protected field write passes only if its function is unlocked; group
  // code 3 names no lock group and is never held back
  always_comb begin
    if (guard_group == 2'h3) begin
      guard_ok = guard_req;
    end else begin
      guard_ok = guard_req && !r_q.lock[guard_group][guard_bit]; // [RL10]
    end
  end

  assign reg_rdata         = r_q.rdata;
  assign reg_rvalid        = r_q.rvalid;
  assign lock_state_first  = r_q.lock[0];
  assign lock_state_second = r_q.lock[1];
  assign lock_state_third  = r_q.lock[2];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_unlock_clears : assert property ( // [RL1]
    (pw_wr[0] && reg_wdata == `FLR_CODE_UNLOCK) |=>
      lock_state_first == ($past(lock_state_first) & $past(lock_exclusion_first)))
    else $error("unlock code did not clear unmasked functions");

  a_lock_sets : assert property ( // [RL2]
    (pw_wr[1] && reg_wdata == `FLR_CODE_LOCK) |=>
      lock_state_second == ($past(lock_state_second) | ~$past(lock_exclusion_second)))
    else $error("lock code did not set unmasked functions");

  a_other_code_hold : assert property ( // [RL3]
    (reg_wr && reg_wdata != `FLR_CODE_LOCK && reg_wdata != `FLR_CODE_UNLOCK) |=>
      $stable(lock_state_first) && $stable(lock_state_second) && $stable(lock_state_third))
    else $error("other code changed lock state");

  a_own_group_only : assert property ( // [RL4]
    pw_wr[2] |=> $stable(lock_state_first) && $stable(lock_state_second))
    else $error("third password touched another group");

  a_read_live_state : assert property ( // [RL5]
    (reg_rd && reg_addr == `FLR_ADDR_PW_THIRD) |=>
      reg_rvalid && reg_rdata == $past(lock_state_third))
    else $error("password read did not return lock state");

  a_masked_kept : assert property ( // [RL11]
    pw_wr[0] |=> ((lock_state_first ^ $past(lock_state_first)) & $past(lock_exclusion_first)) == 8'h00)
    else $error("masked function changed lock state");

  a_readback_sel : assert property ( // [RL8]
    (reg_wr && reg_addr == `FLR_ADDR_OTP_SEL) ##1 (reg_rd && reg_addr == `FLR_ADDR_OTP_DATA) |=>
      reg_rdata == $past(otp_byte) && r_q.sel == $past(reg_wdata, 2))
    else $error("readback did not follow the select register");

  a_guard_blocks : assert property ( // [RL10]
    (guard_req && guard_group != 2'h3 && r_q.lock[guard_group][guard_bit]) |-> !guard_ok)
    else $error("write to a locked function was let through");

  a_data_read_only : assert property ( // [RL12]
    (reg_wr && reg_addr == `FLR_ADDR_OTP_DATA) |=> $stable(r_q.sel) && $stable(r_q.lock))
    else $error("write to readback data changed state");

  // the same checks for the groups not watched above, so a crossed mask or a
  // swapped group index cannot hide behind the one group that is covered
  a_unlock_second : assert property ( // [RL1]
    (pw_wr[1] && reg_wdata == `FLR_CODE_UNLOCK) |=>
      lock_state_second == ($past(lock_state_second) & $past(lock_exclusion_second)))
    else $error("unlock code did not clear unmasked functions of the second group");

  a_unlock_third : assert property ( // [RL1]
    (pw_wr[2] && reg_wdata == `FLR_CODE_UNLOCK) |=>
      lock_state_third == ($past(lock_state_third) & $past(lock_exclusion_third)))
    else $error("unlock code did not clear unmasked functions of the third group");

  a_lock_first : assert property ( // [RL2]
    (pw_wr[0] && reg_wdata == `FLR_CODE_LOCK) |=>
      lock_state_first == ($past(lock_state_first) | ~$past(lock_exclusion_first)))
    else $error("lock code did not set unmasked functions of the first group");

  a_lock_third : assert property ( // [RL2]
    (pw_wr[2] && reg_wdata == `FLR_CODE_LOCK) |=>
      lock_state_third == ($past(lock_state_third) | ~$past(lock_exclusion_third)))
    else $error("lock code did not set unmasked functions of the third group");

  a_first_only : assert property ( // [RL4]
    pw_wr[0] |=>
      $stable(lock_state_second) && $stable(lock_state_third))
    else $error("first password touched another group");

  a_second_only : assert property ( // [RL4]
    pw_wr[1] |=>
      $stable(lock_state_first) && $stable(lock_state_third))
    else $error("second password touched another group");

  a_read_first : assert property ( // [RL5]
    (reg_rd && reg_addr == `FLR_ADDR_PW_FIRST) |=>
      reg_rvalid && reg_rdata == $past(lock_state_first))
    else $error("first password read did not return lock state");

  a_read_second : assert property ( // [RL5]
    (reg_rd && reg_addr == `FLR_ADDR_PW_SECOND) |=>
      reg_rvalid && reg_rdata == $past(lock_state_second))
    else $error("second password read did not return lock state");

  a_masked_second : assert property ( // [RL11]
    pw_wr[1] |=>
      ((lock_state_second ^ $past(lock_state_second)) & $past(lock_exclusion_second)) == 8'h00)
    else $error("masked function of the second group changed lock state");

  a_masked_third : assert property ( // [RL11]
    pw_wr[2] |=>
      ((lock_state_third ^ $past(lock_state_third)) & $past(lock_exclusion_third)) == 8'h00)
    else $error("masked function of the third group changed lock state");

  // lock state moves only on a password write, never on its own
  a_idle_lock : assert property ( // [RL3]
    !(pw_wr[0] || pw_wr[1] || pw_wr[2]) |=>
      $stable(r_q.lock))
    else $error("lock state changed without a password write");

  a_read_pulse : assert property ( // [RL5]
    reg_rd |=>
      reg_rvalid)
    else $error("read strobe gave no valid pulse");

  a_rdata_holds : assert property ( // [RL5]
    !reg_rd |=>
      !reg_rvalid && $stable(reg_rdata))
    else $error("read data moved without a read");

  a_sel_write : assert property ( // [RL8]
    (reg_wr && reg_addr == `FLR_ADDR_OTP_SEL) |=>
      r_q.sel == $past(reg_wdata))
    else $error("select register did not take the written byte");

  a_sel_holds : assert property ( // [RL8]
    !(reg_wr && reg_addr == `FLR_ADDR_OTP_SEL) |=>
      $stable(r_q.sel))
    else $error("select register moved without a write");

  a_read_sel : assert property ( // [RL8]
    (reg_rd && reg_addr == `FLR_ADDR_OTP_SEL) |=>
      reg_rdata == $past(r_q.sel))
    else $error("select register read did not return the select value");

  // a half loaded file must never leak into readback
  a_early_readback : assert property ( // [RL9]
    (reg_rd && reg_addr == `FLR_ADDR_OTP_DATA && !boot_done) |=>
      reg_rdata == `FLR_DATA_RST)
    else $error("readback showed data before the load finished");

  a_no_late_request : assert property ( // [RL9]
    boot_done |->
      !nvm_rd_en)
    else $error("loader asked for a byte after the load finished");

  a_done_holds : assert property ( // [RL9]
    boot_done |=>
      boot_done)
    else $error("load finished flag dropped");

  a_guard_free : assert property ( // [RL10]
    (guard_req && (guard_group == 2'h3 || !r_q.lock[guard_group][guard_bit])) |->
      guard_ok)
    else $error("write to an unlocked function was held back");

  a_guard_idle : assert property ( // [RL10]
    !guard_req |->
      !guard_ok)
    else $error("protected write let through without a request");

endmodule

//--- src/flr_otp_file.sv
// otp register file: copied from the nonvolatile block once after reset
// assumes the nonvolatile block answers each read with nvm_rd_valid on clk
`timescale 1ns/1ps
`include "flr_params.svh"

module flr_otp_file (
  input  wire logic       clk,           // register clock
  input  wire logic       rst_n,         // async reset, active low
  output logic            nvm_rd_en,     // read request to nonvolatile block
  output logic [7:0]      nvm_rd_addr,   // byte address of the request
  input  wire logic       nvm_rd_valid,  // read data is present
  input  wire logic [7:0] nvm_rd_data,   // read data
  input  wire logic [7:0] rd_sel,        // byte chosen for readback
  output logic [7:0]      rd_byte,       // chosen byte of the register file
  output logic            boot_done      // whole file has been loaded
);

  flr_pkg::flr_otp_st_t s_q, s_d;
  logic [7:0] mem [`FLR_OTP_DEPTH];

  // walk every byte in order; one request outstanding at a time
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      flr_pkg::FLR_BOOT_REQ: begin
        s_d.st = flr_pkg::FLR_BOOT_WAIT;
      end
      flr_pkg::FLR_BOOT_WAIT: begin
        if (nvm_rd_valid) begin
          if (s_q.addr == `FLR_OTP_LAST) begin
            s_d.st   = flr_pkg::FLR_READY;
            s_d.done = 1'b1;
          end else begin
            s_d.st   = flr_pkg::FLR_BOOT_REQ;
            s_d.addr = s_q.addr + 8'h01;
          end
        end
      end
      flr_pkg::FLR_READY: begin
        s_d.done = 1'b1;
      end
      default: begin
        s_d.st = flr_pkg::FLR_BOOT_REQ;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: flr_pkg::FLR_BOOT_REQ, addr: 8'h00, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // file storage has no reset; boot fills every byte before use [RL9]
  always_ff @(posedge clk) begin
    if (s_q.st == flr_pkg::FLR_BOOT_WAIT && nvm_rd_valid) begin
      mem[s_q.addr] <= nvm_rd_data;
    end
  end

  assign nvm_rd_en   = (s_q.st == flr_pkg::FLR_BOOT_REQ);
  assign nvm_rd_addr = s_q.addr;
  assign boot_done   = s_q.done;
  // bytes read as zero until the load has finished
  assign rd_byte     = s_q.done ? mem[rd_sel] : `FLR_DATA_RST;

  a_boot_store : assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
    (s_q.st == flr_pkg::FLR_BOOT_WAIT && nvm_rd_valid) |=> mem[$past(s_q.addr)] == $past(nvm_rd_data))
    else $error("boot load did not store the byte");

endmodule
